/* File: core/jesd_link_sync.sv */
// Link synchronisation, frame and multi-frame alignment, and lane output
//
// Overview of operation
// R1 - A low sync request level from the receiver means synchronisation is requested.
// R2 - The sync request is asynchronous and passes two flops before use.
// R3 - Frame and multi-frame rates must match those set in the receiver.
// R4 - After reset the frame and multi-frame counters start at a fixed phase.
// R5 - Controller enables the reference driver, opens the gate, then applies the reference.
// R6 - After the reference, the controller closes the gate so later edges are ignored.
// R7 - The reference driver goes idle only after the gate is closed.
// R8 - Power-down or sleep stops the frame clocks and breaks the link.
// R9 - Any change of the clock divider setting stops the clocks and breaks the link.
// R10 - A sync request breaks the link and restarts synchronisation.
// R11 - A gated reference edge off the current phase realigns clocks and breaks link.
// R12 - A gated reference edge on the current phase changes nothing.
// R13 - Loss of device clock breaks the link; clocks restart when it returns.
// R14 - A continuous reference runs at the multi-frame rate or an integer fraction.
// R15 - Burst reference pulses are spaced by whole multi-frame periods.
// R16 - Each lane has settable output swing and de-emphasis with usable defaults.
// R17 - Optional lane data scrambling can be enabled.
// R18 - Settings are reached over a four-wire serial port with active-low select.
// R19 - Only the rising edge of the reference is used for alignment.
// R20 - Reference already high when the gate opens counts as a rising edge.
// R21 - Every reference pulse stays high for at least two frame periods.
// R22 - Multi-frame clock is the frame clock divided by frames per multi-frame.
`timescale 1ns/100ps
`include "jesd_link_params.svh"
module jesd_link_sync #(
    parameter int SAMPLE_W = 16,
    parameter int FIFO_DEPTH = 16
) (
    input wire logic mclk_i,
    input wire logic nrst_i,
    input wire logic sync_request_n_i,
    input wire logic sysref_i,
    input wire logic device_clock_input_present_i,
    input wire logic [SAMPLE_W-1:0] sample_i,
    input wire logic sample_valid_i,
    output logic sample_ready_o,
    input wire logic sclk_i,
    input wire logic chip_select_n_i,
    input wire logic serial_data_in_i,
    output logic serial_data_out_o,
    output logic serial_data_out_oe_o,
    output logic [15:0] lane_data_o,
    output logic lane_valid_o,
    output logic link_up_o,
    output logic cgs_o,
    output logic link_break_o,
    output logic realign_o,
    output logic frame_clk_o,
    output logic mframe_clk_o,
    output logic [3:0] output_swing_control_o,
    output logic [3:0] deemphasis_setting_o,
    output logic scramble_en_o
);
    import jesd_link_pkg::*;

    cfg_if cfg ();

    logic [SAMPLE_W-1:0] fifo_data;
    logic fifo_valid, pop;
    logic sync_meta_q, sync_q, gated_q, gated, sref_rise, aligned, realign, stop_cond, tick;
    logic [1:0] div_q, div_cnt_q, div_cnt_d, lim;
    logic [7:0] mf_q, mf_d;
    link_state_t state_q, state_d;
    logic [15:0] lane_q, lane_d;
    logic [14:0] scr_q, scr_d;
    logic lane_v_q, lane_v_d, brk_q, brk_d, rea_q, fclk_q, mclk_q, up_q, cgs_q;
    logic [3:0] swing_q, deemph_q;
    logic scr_en_q;
    scr_res_t scr_res;

    // ------------------------------------------------------------------------
    // Submodules
    // ------------------------------------------------------------------------
    cfg_serial_port u_cfg (
        .mclk_i(mclk_i),
        .nrst_i(nrst_i),
        .sclk_i(sclk_i),
        .chip_select_n_i(chip_select_n_i),
        .serial_data_in_i(serial_data_in_i),
        .serial_data_out_o(serial_data_out_o),
        .serial_data_out_oe_o(serial_data_out_oe_o),
        .cfg(cfg.spi)
    );

    // Stalls while the link is not carrying data, so the source feels it
    sample_fifo #(.WIDTH(SAMPLE_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .mclk_i(mclk_i),
        .nrst_i(nrst_i),
        .in_data_i(sample_i),
        .in_valid_i(sample_valid_i),
        .in_ready_o(sample_ready_o),
        .out_data_o(fifo_data),
        .out_valid_o(fifo_valid),
        .out_ready_i(pop)
    );

    assign cfg.state = state_q;

    // ------------------------------------------------------------------------
    // Scrambler 1 + x^14 + x^15, MSB first
    // ------------------------------------------------------------------------
    function automatic scr_res_t scramble(input logic [15:0] d, input logic [14:0] st);
        scr_res_t r;
        r.st = st;
        r.q = 16'h0000;
        for (int i = 15; i >= 0; i--) begin
            r.q[i] = d[i] ^ r.st[14] ^ r.st[13];
            r.st = {r.st[13:0], r.q[i]};
        end
        return r;
    endfunction : scramble

    // ------------------------------------------------------------------------
    // Alignment and link control
    // ------------------------------------------------------------------------
    // Rising edge of the gated level; a high level at gate opening is an edge
    always_comb begin
        gated = sysref_i && cfg.gate_en;
        sref_rise = gated && !gated_q; // R19 R20
        unique case (div_q)
            2'h0: lim = 2'h0;
            2'h1: lim = 2'h1;
            default: lim = 2'h3;
        endcase
        tick = (div_cnt_q == lim);
        aligned = (div_cnt_q == 2'h0) && (mf_q == 8'h00);
        stop_cond = cfg.pwr_down || cfg.sleep || !device_clock_input_present_i
            || (div_q != cfg.div_sel); // R8 R9 R13
        realign = sref_rise && !aligned && !stop_cond; // R11 R12
        div_cnt_d = tick ? 2'h0 : div_cnt_q + 2'h1;
        mf_d = mf_q;
        if (tick) begin
            mf_d = (mf_q >= cfg.k_m1) ? 8'h00 : mf_q + 8'h01; // R22 R3
        end
        if (stop_cond) begin
            div_cnt_d = 2'h0; // R8 R9 R13
            mf_d = 8'h00;
        end else if (realign) begin
            // Land one cycle past the boundary that the edge marks
            div_cnt_d = (lim == 2'h0) ? 2'h0 : 2'h1; // R11
            mf_d = (lim == 2'h0 && cfg.k_m1 != 8'h00) ? 8'h01 : 8'h00;
        end
        state_d = state_q;
        if (stop_cond) begin
            state_d = LS_STOPPED;
        end else begin
            unique case (state_q)
                LS_STOPPED: state_d = LS_CGS; // R13
                LS_CGS: state_d = (sync_q && !realign) ? LS_WAIT_MF : LS_CGS; // R1
                LS_WAIT_MF: begin
                    if (!sync_q || realign) begin
                        state_d = LS_CGS; // R10 R11
                    end else if (tick && mf_q == cfg.k_m1) begin
                        state_d = LS_DATA;
                    end
                end
                LS_DATA: state_d = (!sync_q || realign) ? LS_CGS : LS_DATA; // R10 R11
            endcase
        end
        brk_d = (state_q == LS_WAIT_MF || state_q == LS_DATA)
            && (state_d == LS_CGS || state_d == LS_STOPPED);
    end

    // Two-flop sync of the request; resets to the request level so no false start
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            sync_meta_q <= 1'b0;
            sync_q <= 1'b0;
            gated_q <= 1'b0;
            div_q <= 2'h0;
            div_cnt_q <= 2'h0; // R4
            mf_q <= 8'h00;
            state_q <= LS_STOPPED;
            brk_q <= 1'b0;
            rea_q <= 1'b0;
            fclk_q <= 1'b0;
            mclk_q <= 1'b0;
            up_q <= 1'b0;
            cgs_q <= 1'b0;
        end else begin
            sync_meta_q <= sync_request_n_i; // R2
            sync_q <= sync_meta_q;
            gated_q <= gated;
            div_q <= cfg.div_sel;
            div_cnt_q <= div_cnt_d;
            mf_q <= mf_d;
            state_q <= state_d;
            brk_q <= brk_d;
            rea_q <= realign;
            fclk_q <= !stop_cond && (div_cnt_d == 2'h0);
            mclk_q <= !stop_cond && (div_cnt_d == 2'h0) && (mf_d == 8'h00);
            up_q <= (state_d == LS_DATA);
            cgs_q <= (state_d == LS_CGS);
        end
    end

    // ------------------------------------------------------------------------
    // Lane word generation
    // ------------------------------------------------------------------------
    // Fill word while synchronising or when the FIFO runs dry in data state
    always_comb begin
        pop = (state_q == LS_DATA) && tick && !stop_cond;
        scr_res = scramble(fifo_data, scr_q);
        lane_d = lane_q;
        lane_v_d = 1'b0;
        scr_d = scr_q;
        if (tick && state_q != LS_STOPPED && !stop_cond) begin
            lane_v_d = 1'b1;
            lane_d = `FILL_WORD;
            if (state_q == LS_DATA && fifo_valid) begin
                lane_d = cfg.scr_en ? scr_res.q : fifo_data; // R17
                scr_d = cfg.scr_en ? scr_res.st : scr_q;
            end
        end
    end

    // Lane settings are re-registered so the pins come from local flops
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            lane_q <= 16'h0000;
            lane_v_q <= 1'b0;
            scr_q <= `SCR_SEED;
            swing_q <= 4'h0;
            deemph_q <= 4'h0;
            scr_en_q <= 1'b0;
        end else begin
            lane_q <= lane_d;
            lane_v_q <= lane_v_d;
            scr_q <= scr_d;
            swing_q <= cfg.swing; // R16
            deemph_q <= cfg.deemph; // R16
            scr_en_q <= cfg.scr_en;
        end
    end

    assign lane_data_o = lane_q;
    assign lane_valid_o = lane_v_q;
    assign link_up_o = up_q;
    assign cgs_o = cgs_q;
    assign link_break_o = brk_q;
    assign realign_o = rea_q;
    assign frame_clk_o = fclk_q;
    assign mframe_clk_o = mclk_q;
    assign output_swing_control_o = swing_q;
    assign deemphasis_setting_o = deemph_q;
    assign scramble_en_o = scr_en_q;

    // ------------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------------
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!nrst_i);

    a_sync_two_flop: assert property ($past(nrst_i) && $past(nrst_i, 2) // R2
        |-> sync_q == $past(sync_request_n_i, 2)) else $error("sync request not two-flop");

    a_req_breaks: assert property (!sync_q && state_q inside {LS_WAIT_MF, LS_DATA} // R10
        |=> state_q inside {LS_CGS, LS_STOPPED} && link_break_o) else $error("request kept link");

    a_req_holds_cgs: assert property (!sync_q && state_q == LS_CGS // R1
        |=> state_q != LS_WAIT_MF) else $error("left CGS under request");

    a_pd_stops: assert property (cfg.pwr_down || cfg.sleep // R8
        |=> state_q == LS_STOPPED && mf_q == 8'h00 && !frame_clk_o) else $error("pd kept clocks");

    a_div_change: assert property (div_q != cfg.div_sel // R9
        |=> state_q == LS_STOPPED && div_cnt_q == 2'h0) else $error("divider change kept link");

    a_clk_loss: assert property (!device_clock_input_present_i // R13
        |=> state_q == LS_STOPPED && !frame_clk_o) else $error("clock loss not handled");

    a_clk_return: assert property (state_q == LS_STOPPED && !stop_cond // R13
        |=> state_q == LS_CGS) else $error("no restart after stop");

    a_misalign: assert property (realign && state_q == LS_DATA // R11
        |=> realign_o && state_q == LS_CGS && link_break_o) else $error("misaligned edge kept");

    a_aligned_keeps: assert property (sref_rise && aligned && state_q == LS_DATA && sync_q // R12
        && !stop_cond |=> state_q == LS_DATA && !realign_o) else $error("aligned edge broke");

    a_level_no_edge: assert property (gated && gated_q |=> !realign_o) // R19
        else $error("high level realigned");

    a_gate_open_high: assert property (sysref_i && $rose(cfg.gate_en) && !aligned // R20
        && !stop_cond |=> realign_o) else $error("open on high ignored");

    a_mf_wrap: assert property (tick && mf_q == cfg.k_m1 && !realign && !stop_cond // R22
        |=> mf_q == 8'h00 && mframe_clk_o) else $error("multiframe did not wrap");

    a_plain_data: assert property (pop && fifo_valid && !cfg.scr_en // R17
        |=> lane_data_o == $past(fifo_data) && lane_valid_o) else $error("raw data altered");

    // Main scenarios
    c_data_reached: cover property (state_q == LS_WAIT_MF ##1 state_q == LS_DATA);
    c_clock_back: cover property (!device_clock_input_present_i ##1 device_clock_input_present_i);
    c_realign_seen: cover property (realign_o);
    c_aligned_edge: cover property (sref_rise && aligned && state_q == LS_DATA);
    c_fifo_full: cover property (!sample_ready_o && state_q == LS_CGS);
endmodule : jesd_link_sync

/* File: inc/jesd_link_params.svh */
// Offsets, field positions, reset values and constants of the link alignment block
`ifndef JESD_LINK_PARAMS_SVH
`define JESD_LINK_PARAMS_SVH

// ----------------------------------------------------------------------------
// Serial port register offsets
// ----------------------------------------------------------------------------
`define ADDR_KM1 7'h01
`define ADDR_CTRL 7'h02
`define ADDR_SERDES 7'h03
`define ADDR_STATUS 7'h04

// ----------------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------------
`define CTRL_DIV_LSB 0
`define CTRL_SCR_BIT 2
`define CTRL_GATE_BIT 3
`define CTRL_PDN_BIT 4
`define CTRL_SLEEP_BIT 5
`define SERDES_SWING_LSB 0
`define SERDES_DEEMPH_LSB 4
`define KM1_RESET 8'h13
`define CTRL_RESET 8'h00
`define SERDES_RESET 8'h08

// ----------------------------------------------------------------------------
// Lane constants
// ----------------------------------------------------------------------------
`define FILL_WORD 16'hbcbc
`define SCR_SEED 15'h7fff

`endif

/* File: inc/jesd_link_pkg.sv */
// Types shared by the link alignment block
package jesd_link_pkg;
    typedef enum logic [1:0] {
        LS_STOPPED,
        LS_CGS,
        LS_WAIT_MF,
        LS_DATA
    } link_state_t;

    typedef struct packed {
        logic [14:0] st;
        logic [15:0] q;
    } scr_res_t;
endpackage : jesd_link_pkg

/* File: inc/cfg_if.sv */
// Configuration and status carried between the serial port and the link core
`timescale 1ns/100ps
interface cfg_if;
    logic [7:0] k_m1;
    logic [1:0] div_sel;
    logic [3:0] swing;
    logic [3:0] deemph;
    logic scr_en;
    logic gate_en;
    logic pwr_down;
    logic sleep;
    jesd_link_pkg::link_state_t state;

    modport spi (output k_m1, div_sel, swing, deemph, scr_en, gate_en, pwr_down, sleep,
                 input state);
    modport core (input k_m1, div_sel, swing, deemph, scr_en, gate_en, pwr_down, sleep,
                  output state);
endinterface : cfg_if

/* File: core/sample_fifo.sv */
// Sample FIFO with registered ready toward the source
`timescale 1ns/100ps
module sample_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16
) (
    input wire logic mclk_i,
    input wire logic nrst_i,
    input wire logic [WIDTH-1:0] in_data_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    output logic [WIDTH-1:0] out_data_o,
    output logic out_valid_o,
    input wire logic out_ready_i
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] DEPTH_C = AW'(DEPTH) == 0 ? {1'b1, {AW{1'b0}}} : (AW+1)'(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
    logic [AW:0] cnt_q, cnt_d;
    logic rdy_q, rdy_d;
    logic push, pop;

    // ------------------------------------------------------------------------
    // Pointers and fill level
    // ------------------------------------------------------------------------
    // Ready is registered from the next level so the source sees a flop
    always_comb begin
        push = in_valid_i && rdy_q;
        pop = out_ready_i && (cnt_q != '0);
        wr_d = push ? ((wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1) : wr_q;
        rd_d = pop ? ((rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1) : rd_q;
        cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        rdy_d = (cnt_d != DEPTH_C);
    end

    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
            rdy_q <= 1'b0;
        end else begin
            wr_q <= wr_d;
            rd_q <= rd_d;
            cnt_q <= cnt_d;
            rdy_q <= rdy_d;
        end
    end

    // Storage has no reset; only written words are ever read
    always_ff @(posedge mclk_i) begin
        if (push) begin
            mem[wr_q] <= in_data_i;
        end
    end

    assign in_ready_o = rdy_q;
    assign out_valid_o = (cnt_q != '0);
    assign out_data_o = mem[rd_q];
endmodule : sample_fifo

/* File: core/cfg_serial_port.sv */
// Four-wire configuration port holding the link settings
`timescale 1ns/100ps
`include "jesd_link_params.svh"
module cfg_serial_port (
    input wire logic mclk_i,
    input wire logic nrst_i,
    input wire logic sclk_i,
    input wire logic chip_select_n_i,
    input wire logic serial_data_in_i,
    output logic serial_data_out_o,
    output logic serial_data_out_oe_o,
    cfg_if.spi cfg
);
    import jesd_link_pkg::*;

    logic sclk_q, sclk_d, rw_q, rw_d, sdo_q, sdo_d, oe_q, oe_d;
    logic [3:0] cnt_q, cnt_d;
    logic [15:0] sh_q, sh_d;
    logic [7:0] rd_q, rd_d, km1_q, km1_d, ctrl_q, ctrl_d, serdes_q, serdes_d, rmux;

    // ------------------------------------------------------------------------
    // Frame: read flag, 7-bit address, 8-bit data, MSB first
    // ------------------------------------------------------------------------
    // Serial clock is sampled, so it must run well below the core clock
    always_comb begin
        sclk_d = sclk_i;
        cnt_d = cnt_q;
        sh_d = sh_q;
        rw_d = rw_q;
        rd_d = rd_q;
        sdo_d = sdo_q;
        oe_d = oe_q;
        km1_d = km1_q;
        ctrl_d = ctrl_q;
        serdes_d = serdes_q;
        unique case ({sh_q[5:0], serial_data_in_i}) // Address once the 8th bit lands
            `ADDR_KM1: rmux = km1_q;
            `ADDR_CTRL: rmux = ctrl_q;
            `ADDR_SERDES: rmux = serdes_q;
            `ADDR_STATUS: rmux = {6'h00, cfg.state};
            default: rmux = 8'h00;
        endcase
        if (chip_select_n_i) begin
            cnt_d = 4'h0;
            oe_d = 1'b0;
        end else if (sclk_i && !sclk_q) begin
            sh_d = {sh_q[14:0], serial_data_in_i};
            cnt_d = cnt_q + 4'h1;
            if (cnt_q == 4'h7) begin
                rw_d = sh_d[7];
                rd_d = rmux;
            end
            if (cnt_q == 4'hf && !rw_q) begin // R18
                unique case (sh_d[14:8])
                    `ADDR_KM1: km1_d = sh_d[7:0];
                    `ADDR_CTRL: ctrl_d = sh_d[7:0];
                    `ADDR_SERDES: serdes_d = sh_d[7:0];
                    default: ;
                endcase
            end
        end else if (!sclk_i && sclk_q && rw_q && (cnt_q >= 4'h8 || cnt_q == 4'h0)) begin
            sdo_d = rd_q[7];
            rd_d = {rd_q[6:0], 1'b0};
            oe_d = 1'b1;
        end
    end

    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            sclk_q <= 1'b0;
            cnt_q <= 4'h0;
            sh_q <= 16'h0000;
            rw_q <= 1'b0;
            rd_q <= 8'h00;
            sdo_q <= 1'b0;
            oe_q <= 1'b0;
            km1_q <= `KM1_RESET;
            ctrl_q <= `CTRL_RESET;
            serdes_q <= `SERDES_RESET;
        end else begin
            sclk_q <= sclk_d;
            cnt_q <= cnt_d;
            sh_q <= sh_d;
            rw_q <= rw_d;
            rd_q <= rd_d;
            sdo_q <= sdo_d;
            oe_q <= oe_d;
            km1_q <= km1_d;
            ctrl_q <= ctrl_d;
            serdes_q <= serdes_d;
        end
    end

    assign serial_data_out_o = sdo_q;
    assign serial_data_out_oe_o = oe_q;
    assign cfg.k_m1 = km1_q;
    assign cfg.div_sel = ctrl_q[`CTRL_DIV_LSB +: 2];
    assign cfg.scr_en = ctrl_q[`CTRL_SCR_BIT];
    assign cfg.gate_en = ctrl_q[`CTRL_GATE_BIT];
    assign cfg.pwr_down = ctrl_q[`CTRL_PDN_BIT];
    assign cfg.sleep = ctrl_q[`CTRL_SLEEP_BIT];
    assign cfg.swing = serdes_q[`SERDES_SWING_LSB +: 4];
    assign cfg.deemph = serdes_q[`SERDES_DEEMPH_LSB +: 4];
endmodule : cfg_serial_port

/* File: test/far_end_model.sv */
// Far-end model: serial data receiver and reference clock generator
`timescale 1ns/100ps
module far_end_model (
    input wire logic mclk_i,
    output logic sync_request_n_o,
    output logic sysref_o
);
    // Receiver asks for sync from power-up; reference driver starts idle
    initial begin
        sync_request_n_o = 1'b0;
        sysref_o = 1'b0;
    end
    // Low level asks the transmitter to resynchronise
    task automatic set_sync(input logic ok);
        @(negedge mclk_i);
        sync_request_n_o = ok;
    endtask : set_sync
    // Gap counted in whole cycles so bursts land on multi-frame spacing; high for two frames+
    task automatic pulse(input int gap);
        repeat (gap) @(negedge mclk_i);
        sysref_o = 1'b1;
        repeat (4) @(negedge mclk_i);
        sysref_o = 1'b0;
    endtask : pulse
endmodule : far_end_model

/* File: test/jesd_link_sync_tb.sv */
// Self-checking bench for the link synchronisation block
`timescale 1ns/100ps
`include "jesd_link_params.svh"
module jesd_link_sync_tb;
    typedef struct {
        logic [6:0] ad;
        logic [7:0] d;
        logic [3:0] sw;
        logic [3:0] de;
        logic scr;
        int brk;
        logic up;
    } row_t;
    logic mclk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic device_clock_input_present_i = 1'b1;
    logic sysref_i, sync_request_n_i, sample_ready_o, serial_data_out_o, serial_data_out_oe_o;
    logic [15:0] sample_i, lane_data_o;
    logic sample_valid_i, sclk_i, chip_select_n_i, serial_data_in_i;
    logic lane_valid_o, link_up_o, cgs_o, link_break_o, realign_o, frame_clk_o, mframe_clk_o;
    logic scramble_en_o;
    logic feed = 1'b0;
    logic [3:0] output_swing_control_o, deemphasis_setting_o;
    logic [7:0] rd;
    int num_errors = 0, samples_checked = 0, n_brk = 0, n_al = 0, n_frm = 0, acc = 0, b, a;
    row_t rows [9] = '{'{`ADDR_SERDES, 8'h35, 4'h5, 4'h3, 0, 0, 1},
        '{`ADDR_CTRL, 8'h04, 4'h5, 4'h3, 1, 0, 1}, '{`ADDR_CTRL, 8'h10, 4'h5, 4'h3, 0, 1, 0},
        '{`ADDR_CTRL, 8'h04, 4'h5, 4'h3, 1, 0, 0}, '{`ADDR_CTRL, 8'h24, 4'h5, 4'h3, 1, 1, 0},
        '{`ADDR_CTRL, 8'h05, 4'h5, 4'h3, 1, 0, 0}, '{`ADDR_CTRL, 8'h06, 4'h5, 4'h3, 1, 1, 0},
        '{`ADDR_CTRL, 8'h04, 4'h5, 4'h3, 1, 1, 0}, '{`ADDR_CTRL, 8'h00, 4'h5, 4'h3, 0, 0, 1}};

    jesd_link_sync dut (.mclk_i, .nrst_i, .sync_request_n_i, .sysref_i, .device_clock_input_present_i,
        .sample_i, .sample_valid_i, .sample_ready_o, .sclk_i, .chip_select_n_i,
        .serial_data_in_i, .serial_data_out_o, .serial_data_out_oe_o, .lane_data_o,
        .lane_valid_o, .link_up_o, .cgs_o, .link_break_o, .realign_o, .frame_clk_o,
        .mframe_clk_o, .output_swing_control_o, .deemphasis_setting_o, .scramble_en_o);
    far_end_model fe (.mclk_i, .sync_request_n_o(sync_request_n_i), .sysref_o(sysref_i));

    // 100 MHz clock
    always #5 mclk_i = ~mclk_i;
    // Event counters; the sample source offers 20 words so the full buffer must refuse some
    always @(posedge mclk_i) begin
        n_brk <= n_brk + int'(link_break_o);
        n_al <= n_al + int'(realign_o);
        n_frm <= n_frm + int'(frame_clk_o);
        acc <= !feed ? 0 : acc + int'(sample_valid_i && sample_ready_o);
    end
    // Samples change on the falling edge only
    always @(negedge mclk_i) begin
        sample_valid_i <= feed && acc < 20;
        sample_i <= 16'h1000 + acc[15:0];
    end

    // ----
    // Tasks
    // ----
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string s);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t: %s got %h expected %h", $time, s, got, exp);
        end
    endtask : chk
    task automatic end_of_test();
        $display("checks %0d, mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : end_of_test
    task automatic cyc(input int n);
        repeat (n) @(negedge mclk_i);
    endtask : cyc
    // Bounded wait for the link to come up
    task automatic wait_up();
        for (a = 0; link_up_o !== 1'b1; a++) begin
            if (a > 3000) begin
                chk(0, 1, "link never came up");
                end_of_test();
            end
            cyc(1);
        end
    endtask : wait_up
    // One 16-bit frame on the configuration port, MSB first; clock low 3, high 2 cycles
    task automatic xfer(input logic r, input logic [6:0] ad, input logic [7:0] wd);
        logic [15:0] f;
        f = {r, ad, wd};
        chip_select_n_i = 1'b0;
        for (int i = 15; i >= 0; i--) begin
            serial_data_in_i = f[i];
            cyc(3);
            rd = {rd[6:0], serial_data_out_o};
            sclk_i = 1'b1;
            cyc(2);
            sclk_i = 1'b0;
        end
        cyc(1);
        chk(serial_data_out_oe_o, r, "drive enable");
        chip_select_n_i = 1'b1;
        cyc(3);
    endtask : xfer

    // ----
    // Main sequence
    // ----
    initial begin
        sclk_i = 1'b0;
        chip_select_n_i = 1'b1;
        serial_data_in_i = 1'b0;
        cyc(16);
        nrst_i = 1'b1;
        cyc(3);
        chk(cgs_o, 1, "sync state after reset");
        fe.set_sync(1'b1);
        wait_up();
        foreach (rows[i]) begin
            b = n_brk;
            xfer(1'b0, rows[i].ad, rows[i].d);
            cyc(4);
            chk(output_swing_control_o, rows[i].sw, "swing");
            chk(deemphasis_setting_o, rows[i].de, "deemphasis");
            chk(scramble_en_o, rows[i].scr, "scramble");
            chk(16'(n_brk - b), 16'(rows[i].brk), "breaks");
            chk(link_up_o, rows[i].up, "link level");
            if (rows[i].d[5:4] == 2'b00) wait_up();
            $display("row %0d done", i);
        end
        b = n_brk;
        fe.set_sync(1'b0);
        cyc(4);
        chk(16'(n_brk - b), 1, "sync request break");
        chk(cgs_o, 1, "resync");
        fe.set_sync(1'b1);
        wait_up();
        b = n_brk;
        device_clock_input_present_i = 1'b0;
        cyc(2);
        a = n_frm;
        cyc(8);
        chk(16'(n_frm - a), 0, "frame clock stopped");
        chk(16'(n_brk - b), 1, "clock loss break");
        device_clock_input_present_i = 1'b1;
        wait_up();
        $display("sync and clock loss tests done");
        b = n_al;
        fe.pulse(3);
        cyc(4);
        chk(16'(n_al - b), 0, "gate closed");
        xfer(1'b0, `ADDR_CTRL, 8'h08);
        for (a = 0; mframe_clk_o !== 1'b1 && a < 100; a++) cyc(1);
        if (a >= 100) chk(0, 1, "no multiframe edge");
        b = n_al;
        a = n_brk;
        fe.pulse(5);
        chk(16'(n_al - b), 1, "misaligned edge");
        chk(16'(n_brk - a), 1, "misaligned break");
        b = n_al;
        a = n_brk;
        fe.pulse(16);
        chk(16'(n_al - b), 0, "aligned edge");
        chk(16'(n_brk - a), 0, "aligned no break");
        xfer(1'b0, `ADDR_CTRL, 8'h00);
        wait_up();
        xfer(1'b1, `ADDR_STATUS, 8'h00);
        chk(rd, 8'h03, "status");
        xfer(1'b1, 7'h7f, 8'h00);
        chk(rd, 8'h00, "unmapped");
        $display("reference tests done");
        fe.set_sync(1'b0);
        nrst_i = 1'b0;
        cyc(2);
        chk({link_up_o, lane_valid_o, cgs_o, realign_o}, 0, "outputs in reset");
        cyc(14);
        nrst_i = 1'b1;
        cyc(3);
        chk({output_swing_control_o, deemphasis_setting_o}, 8'h80, "lane defaults");
        chk(scramble_en_o, 0, "scramble default");
        feed = 1'b1;
        cyc(60);
        chk(16'(acc), 16, "buffer full");
        chk(sample_ready_o, 0, "buffer refuses");
        fe.set_sync(1'b1);
        wait_up();
        for (int i = 0; i < 20; i++) begin
            for (a = 0; a < 200 && !(lane_valid_o === 1'b1 && link_up_o === 1'b1
                && lane_data_o !== `FILL_WORD); a++) cyc(1);
            chk(lane_data_o, 16'h1000 + 16'(i), "lane word");
            cyc(1);
        end
        for (a = 0; a < 200 && lane_valid_o !== 1'b1; a++) cyc(1);
        chk(lane_data_o, `FILL_WORD, "fill after drain");
        $display("reset and buffer tests done");
        end_of_test();
    end
endmodule : jesd_link_sync_tb
